// ---- rtl/pic_pkg.sv ----
// Shared constants and types of the interrupt controller
package pic_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// First init word field positions
	localparam int INIT1_NEED4   = 0;
	localparam int INIT1_SINGLE  = 1;
	localparam int INIT1_LEVEL   = 3;
	localparam int INIT1_START   = 4;

	// Fourth init word field positions
	localparam int INIT4_AUTOEOI = 1;
	localparam int INIT4_MASTER  = 2;
	localparam int INIT4_BUFFER  = 3;

	// Operation word fields
	localparam int OPW_SEL3      = 3;
	localparam int OPW_EOI       = 5;
	localparam int OPW_SPECIFIC  = 6;
	localparam int OPW_RDVALID   = 1;
	localparam int OPW_RDSERV    = 0;

	// Reset values, spurious level and request count
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [2:0] CAS_IDLE   = 3'h0;
	localparam logic [2:0] SPURIOUS   = 3'h7;
	localparam int         NUM_REQ    = 8;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [4:0] {
		IN_IDLE = 5'h01,
		IN_W2   = 5'h02,
		IN_W3   = 5'h04,
		IN_W4   = 5'h08,
		IN_RDY  = 5'h10
	} pic_init_t;

	typedef enum logic [3:0] {
		AK_IDLE = 4'h1,
		AK_P1   = 4'h2,
		AK_GAP  = 4'h4,
		AK_P2   = 4'h8
	} pic_ack_t;

endpackage

// ---- rtl/pic_res_if.sv ----
// Link between the controller core and its priority resolver
`timescale 1ns/1ps
`default_nettype none
interface pic_res_if;
	logic [7:0] pend;
	logic [7:0] serv;
	logic       hit;
	logic [2:0] idx;

	modport resolver (input pend, input serv, output hit, output idx);
	modport user     (output pend, output serv, input hit, input idx);
endinterface
`default_nettype wire

// ---- rtl/pic_prio_res.sv ----
// Fixed priority resolver, line 0 highest, blocked by in-service levels
`timescale 1ns/1ps
`default_nettype none
module pic_prio_res #(
	parameter int N = 8
) (
	pic_res_if.resolver res
);
	logic stop;

	always_comb begin
		res.hit = 1'b0;
		res.idx = 3'h0;
		stop    = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (!stop) begin
				// An equal or higher level in service hides everything below it
				if (res.serv[i]) begin
					stop = 1'b1;
				end else if (res.pend[i]) begin
					res.hit = 1'b1;
					res.idx = i[2:0];
					stop    = 1'b1;
				end
			end
		end
	end
endmodule // pic_prio_res
`default_nettype wire

// ---- rtl/pic_host_cascade.sv ----
// Interrupt controller core: host strobes, acknowledge cycle and cascade bus
`timescale 1ns/1ps
`default_nettype none
module pic_host_cascade (
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       cs_n_in,
	input  wire logic       rd_n_in,
	input  wire logic       wr_n_in,
	input  wire logic       register_select_in,
	input  wire logic [7:0] din_in,
	input  wire logic       inta_n_in,
	input  wire logic       slave_sel_n_in,
	input  wire logic [2:0] cas_in,
	input  wire logic [7:0] request_lines_in,
	output logic            int_out,
	output logic      [2:0] cas_out,
	output logic            cas_en_out,
	output logic      [7:0] dout_out,
	output logic            data_en_n_out
);

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		pic_pkg::pic_init_t init;
		pic_pkg::pic_ack_t  ack;
		logic [7:0]         init1;
		logic [7:0]         init2;
		logic [7:0]         init3;
		logic [7:0]         init4;
		logic [7:0]         imr;
		logic [7:0]         irr;
		logic [7:0]         isr;
		logic               rd_serv;
		logic               wr_prev;
		logic               inta_prev;
		logic [7:0]         req_prev;
		logic [2:0]         idx;
		logic               hit;
		logic               irq;
		logic [2:0]         cas;
		logic               cas_en;
		logic [7:0]         dout;
		logic               den_n;
	} pic_state_t;

	pic_state_t state_q;
	pic_state_t state_d;

	pic_res_if res ();

	pic_prio_res #(
		.N (pic_pkg::NUM_REQ)
	) u_res (
		.res (res.resolver)
	);

	logic       wr_act;
	logic       rd_act;
	logic       wr_take;
	logic       inta_fall;
	logic       inta_rise;
	logic       single;
	logic       buffered;
	logic       is_slave;
	logic       is_master;
	logic       edge_mode;
	logic       own;
	logic [7:0] clr_top;
	logic       found;

	assign res.pend = state_q.irr & ~state_q.imr;
	assign res.serv = state_q.isr;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d   = state_q;
		wr_act    = !cs_n_in && !wr_n_in;
		rd_act    = !cs_n_in && !rd_n_in;
		wr_take   = wr_act && !state_q.wr_prev;
		inta_fall = !inta_n_in && state_q.inta_prev;
		inta_rise = inta_n_in && !state_q.inta_prev;
		single    = state_q.init1[pic_pkg::INIT1_SINGLE];
		buffered  = state_q.init4[pic_pkg::INIT4_BUFFER];
		edge_mode = !state_q.init1[pic_pkg::INIT1_LEVEL];
		// Slave-select only counts in unbuffered cascade mode
		is_slave  = !single && (buffered ? !state_q.init4[pic_pkg::INIT4_MASTER]
		                                 : !slave_sel_n_in);
		is_master = !single && !is_slave;
		// Only a slave compares its cascade input with its init3 id; a master or single unit always owns the acknowledge
		own       = !is_slave || (cas_in == state_q.init3[2:0]);
		clr_top   = 8'h00;
		found     = 1'b0;
		for (int i = 0; i < pic_pkg::NUM_REQ; i++) begin
			if (!found && state_q.isr[i]) begin
				clr_top[i] = 1'b1;
				found      = 1'b1;
			end
		end

		state_d.wr_prev   = wr_act;
		state_d.inta_prev = inta_n_in;
		state_d.req_prev  = request_lines_in;

		// Request sensing; an edge that lands with a clear is kept
		if (state_q.init == pic_pkg::IN_RDY) begin
			if (edge_mode) begin
				state_d.irr = (state_q.irr | (request_lines_in & ~state_q.req_prev))
				              & request_lines_in;
			end else begin
				state_d.irr = request_lines_in;
			end
		end

		// Acknowledge sequence
		case (state_q.ack)
			pic_pkg::AK_IDLE: begin
				if (inta_fall && state_q.init == pic_pkg::IN_RDY) begin
					state_d.hit = res.hit;
					state_d.idx = res.hit ? res.idx : pic_pkg::SPURIOUS;
					state_d.ack = pic_pkg::AK_P1;
					if (is_master && res.hit && state_q.init3[res.idx]) begin
						state_d.cas = res.idx;
					end
				end
			end
			pic_pkg::AK_P1: begin
				if (inta_rise) begin
					state_d.ack = pic_pkg::AK_GAP;
				end
			end
			pic_pkg::AK_GAP: begin
				if (inta_fall) begin
					state_d.ack = pic_pkg::AK_P2;
					if (own) begin
						if (state_q.hit) begin
							state_d.isr[state_q.idx] = 1'b1;
							if (edge_mode) begin
								state_d.irr[state_q.idx] = request_lines_in[state_q.idx] & ~state_q.req_prev[state_q.idx];
							end
						end
						// A master with a slave on this line leaves the bus to it
						if (!(is_master && state_q.init3[state_q.idx])) begin
							state_d.dout  = {state_q.init2[7:3], state_q.idx};
							state_d.den_n = 1'b0;
						end
					end
				end
			end
			pic_pkg::AK_P2: begin
				if (inta_rise) begin
					state_d.ack   = pic_pkg::AK_IDLE;
					state_d.cas   = pic_pkg::CAS_IDLE;
					state_d.dout  = pic_pkg::BYTE_RESET;
					state_d.den_n = 1'b1;
					if (state_q.init4[pic_pkg::INIT4_AUTOEOI] && state_q.hit) begin
						state_d.isr[state_q.idx] = 1'b0;
					end
				end
			end
			default: begin
				state_d.ack = pic_pkg::AK_IDLE;
			end
		endcase

		// Host register read, suspended while the vector is on the bus
		if (state_q.ack != pic_pkg::AK_P2 && state_d.ack != pic_pkg::AK_P2) begin
			state_d.den_n = !rd_act;
			if (!rd_act) begin
				state_d.dout = pic_pkg::BYTE_RESET;
			end else if (register_select_in) begin
				state_d.dout = state_q.imr;
			end else begin
				state_d.dout = state_q.rd_serv ? state_q.isr : state_q.irr;
			end
		end

		// Host register write
		if (wr_take) begin
			if (!register_select_in && din_in[pic_pkg::INIT1_START]) begin
				state_d.init1   = din_in;
				state_d.init4   = pic_pkg::BYTE_RESET;
				state_d.imr     = pic_pkg::BYTE_RESET;
				state_d.isr     = pic_pkg::BYTE_RESET;
				state_d.irr     = pic_pkg::BYTE_RESET;
				state_d.rd_serv = 1'b0;
				state_d.ack     = pic_pkg::AK_IDLE;
				state_d.cas     = pic_pkg::CAS_IDLE;
				state_d.init    = pic_pkg::IN_W2;
			end else begin
				case (state_q.init)
					pic_pkg::IN_W2: begin
						if (register_select_in) begin
							state_d.init2 = din_in;
							if (!single) begin
								state_d.init = pic_pkg::IN_W3;
							end else if (state_q.init1[pic_pkg::INIT1_NEED4]) begin
								state_d.init = pic_pkg::IN_W4;
							end else begin
								state_d.init = pic_pkg::IN_RDY;
							end
						end
					end
					pic_pkg::IN_W3: begin
						if (register_select_in) begin
							state_d.init3 = din_in;
							state_d.init  = state_q.init1[pic_pkg::INIT1_NEED4] ?
							                pic_pkg::IN_W4 : pic_pkg::IN_RDY;
						end
					end
					pic_pkg::IN_W4: begin
						if (register_select_in) begin
							state_d.init4 = din_in;
							state_d.init  = pic_pkg::IN_RDY;
						end
					end
					pic_pkg::IN_RDY: begin
						if (register_select_in) begin
							state_d.imr = din_in;
						end else if (!din_in[pic_pkg::OPW_SEL3]) begin
							if (din_in[pic_pkg::OPW_EOI]) begin
								if (din_in[pic_pkg::OPW_SPECIFIC]) begin
									state_d.isr[din_in[2:0]] = 1'b0;
								end else begin
									state_d.isr = state_d.isr & ~clr_top;
								end
							end
						end else if (din_in[pic_pkg::OPW_RDVALID]) begin
							state_d.rd_serv = din_in[pic_pkg::OPW_RDSERV];
						end
					end
					default: begin
						state_d.init = state_q.init;
					end
				endcase
			end
		end

		// Taking a level into service wins over an end-of-interrupt word in the same cycle
		if (state_q.ack == pic_pkg::AK_GAP && state_d.ack == pic_pkg::AK_P2
		    && own && state_q.hit) begin
			state_d.isr[state_q.idx] = 1'b1;
		end

		state_d.irq    = (state_d.init == pic_pkg::IN_RDY) && (state_d.ack == pic_pkg::AK_IDLE)
		                 && res.hit && (state_q.ack == pic_pkg::AK_IDLE);
		state_d.cas_en = (state_d.init == pic_pkg::IN_RDY) && is_master;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_q           <= '0;
			state_q.init      <= pic_pkg::IN_IDLE;
			state_q.ack       <= pic_pkg::AK_IDLE;
			state_q.den_n     <= 1'b1;
			state_q.inta_prev <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	assign int_out       = state_q.irq;
	assign cas_out       = state_q.cas;
	assign cas_en_out    = state_q.cas_en;
	assign dout_out      = state_q.dout;
	assign data_en_n_out = state_q.den_n;

endmodule // pic_host_cascade
`default_nettype wire

// ---- bench/pic_host_cascade_properties.sv ----
// Port assertions of the interrupt controller core
`timescale 1ns/1ps
`default_nettype none
module pic_host_cascade_properties (
	input wire logic	mclk_in,
	input wire logic	rst_in,
	input wire logic	cs_n_in,
	input wire logic	rd_n_in,
	input wire logic	wr_n_in,
	input wire logic	inta_n_in,
	input wire logic [7:0]	request_lines_in,
	input wire logic	int_out,
	input wire logic [2:0]	cas_out,
	input wire logic	cas_en_out,
	input wire logic [7:0]	dout_out,
	input wire logic	data_en_n_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////
	sequence s_quiet; (cs_n_in || rd_n_in) && inta_n_in; endsequence
	sequence s_vec; (!data_en_n_out && !inta_n_in) ##1 !inta_n_in; endsequence
	property p_rst;
		disable iff (1'b0) rst_in |=> !int_out && cas_out == 3'h0 && !cas_en_out
			&& dout_out == 8'h00 && data_en_n_out;
	endproperty
	property p_rd; !cs_n_in && !rd_n_in && inta_n_in |=> !data_en_n_out; endproperty
	property p_quiet; s_quiet ##1 s_quiet |-> data_en_n_out && dout_out == 8'h00; endproperty
	property p_vec; s_vec |-> !data_en_n_out && $stable(dout_out); endproperty
	// Config may land one or two edges after the write strobe
	property p_cas_en;
		$changed(cas_en_out) |-> $past(rst_in) || $past(!cs_n_in && !wr_n_in)
			|| $past(!cs_n_in && !wr_n_in, 2);
	endproperty
	property p_dout;
		$changed(dout_out) |-> $past(rst_in) || $past(!rd_n_in || !inta_n_in)
			|| $past(!rd_n_in || !inta_n_in, 2);
	endproperty
	property p_den; $fell(data_en_n_out) |-> $past(!inta_n_in || !cs_n_in && !rd_n_in); endproperty
	property p_int;
		$rose(int_out) |-> $past(|request_lines_in) || $past(|request_lines_in, 2)
			|| $past(|request_lines_in, 3);
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs wrong");
	a_rd: assert property (p_rd) else $error("read not enabled");
	a_quiet: assert property (p_quiet) else $error("bus driven when idle");
	a_vec: assert property (p_vec) else $error("vector not held");
	a_cas_en: assert property (p_cas_en) else $error("cascade enable moved");
	a_dout: assert property (p_dout) else $error("data moved unasked");
	a_den: assert property (p_den) else $error("enable without cause");
	a_int: assert property (p_int) else $error("int without request");
endmodule // pic_host_cascade_properties
`default_nettype wire

// ---- bench/pic_cpu_ack.sv ----
// Processor side acknowledge model
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_ack #(
	parameter int GAP = 2
) (
	input  wire logic	clk_in,
	input  wire logic	go_in,
	output var logic	inta_n_out,
	output var logic	busy_out
);
	initial begin
		inta_n_out = 1'b1;
		busy_out = 1'b0;
		forever begin
			@(posedge clk_in);
			if (go_in) begin
				busy_out = 1'b1;
				repeat (2) begin
					@(negedge clk_in) inta_n_out = 1'b0;
					repeat (3) @(negedge clk_in);
					inta_n_out = 1'b1;
					repeat (GAP) @(negedge clk_in);
				end
				busy_out = 1'b0;
			end
		end
	end
endmodule // pic_cpu_ack
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the interrupt controller core
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic		mclk = 1'b0;
	logic		rst = 1'b1;
	logic		cs_n = 1'b1;
	logic		rd_n = 1'b1;
	logic		wr_n = 1'b1;
	logic		sel = 1'b0;
	logic		ssn = 1'b0;
	logic		go = 1'b0;
	logic		den_q = 1'b1;
	logic [7:0]	din = 8'h00;
	logic [7:0]	req = 8'h00;
	logic [2:0]	cas_i = 3'h0;
	logic [31:0]	seed = 32'h7906;
	logic [7:0]	q[$];
	int		bad_count = 0;
	int		num_checks = 0;
	wire logic	inta_n, busy, int_o, cas_en, den_n;
	wire logic [2:0] cas_o;
	wire logic [7:0] dout;
	always #25 mclk = ~mclk;
	pic_host_cascade u_dut (.mclk_in(mclk), .rst_in(rst), .cs_n_in(cs_n), .rd_n_in(rd_n),
		.wr_n_in(wr_n), .register_select_in(sel), .din_in(din), .inta_n_in(inta_n),
		.slave_sel_n_in(ssn), .cas_in(cas_i), .request_lines_in(req), .int_out(int_o),
		.cas_out(cas_o), .cas_en_out(cas_en), .dout_out(dout), .data_en_n_out(den_n));
	// Slow gap between pulses to stress the acknowledge sequencing
	pic_cpu_ack #(.GAP(3)) u_cpu (.clk_in(mclk), .go_in(go), .inta_n_out(inta_n),
		.busy_out(busy));
	////////////////////////////////////////
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Line 0 wins; nothing pending reports level 7
	function automatic logic [7:0] vec(logic [7:0] r);
		for (int i = 0; i < 8; i++)
			if (r[i])
				return 8'h40 | i[7:0];
		return 8'h47;
	endfunction
	task automatic wr(logic c, logic s, logic [7:0] d);
		@(negedge mclk);
		{cs_n, wr_n, sel, din} = {c, 1'b0, s, d};
		@(negedge mclk);
		{cs_n, wr_n} = 2'b11;
		@(negedge mclk);
	endtask
	task automatic rd(logic s, logic [7:0] e);
		q.push_back(e);
		@(negedge mclk);
		{cs_n, rd_n, sel} = {2'b00, s};
		repeat (2) @(negedge mclk);
		{cs_n, rd_n} = 2'b11;
		repeat (2) @(negedge mclk);
	endtask
	task automatic ack(logic [7:0] e, logic drv, logic [2:0] ec);
		if (drv)
			q.push_back(e);
		@(negedge mclk);
		go = 1'b1;
		@(negedge mclk);
		go = 1'b0;
		repeat (3) @(negedge mclk);
		chk("cas", {5'h00, cas_o}, {5'h00, ec});
		for (int i = 0; i < 40 && busy; i++)
			@(posedge mclk);
		@(negedge mclk);
	endtask
	always @(negedge mclk) begin
		if (den_n === 1'b0 && den_q === 1'b1) begin
			if (q.size() > 0)
				chk("dout", dout, q.pop_front());
			else
				chk("unasked", 8'h01, 8'h00);
		end
		den_q <= den_n;
	end
	initial begin
		repeat (3000) @(posedge mclk);
		bad_count++;
		stop_test();
	end
	initial begin
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		chk("idle", {int_o, cas_o, cas_en, den_n, 2'b00}, 8'h04);
		wr(1'b0, 1'b0, 8'h1a);
		wr(1'b0, 1'b1, 8'h40);
		chk("cas_en", {7'h00, cas_en}, 8'h00);
		wr(1'b1, 1'b1, 8'h0f);
		rd(1'b1, 8'h00);
		wr(1'b0, 1'b1, 8'hf0);
		rd(1'b1, 8'hf0);
		req = 8'h30;
		repeat (3) @(negedge mclk);
		chk("int", {7'h00, int_o}, 8'h00);
		wr(1'b0, 1'b0, 8'h0a);
		rd(1'b0, 8'h30);
		wr(1'b0, 1'b1, 8'h00);
		// Slave select held low here must be ignored in single mode
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			req = (k == 7) ? 8'h00 : seed[7:0];
			repeat (3) @(negedge mclk);
			chk("int", {7'h00, int_o}, {7'h00, |req});
			ack(vec(req), 1'b1, 3'h0);
			wr(1'b0, 1'b0, 8'h20);
		end
		// Edge sensing with automatic end of interrupt; the line stays high after service
		wr(1'b0, 1'b0, 8'h13);
		wr(1'b0, 1'b1, 8'h40);
		wr(1'b0, 1'b1, 8'h02);
		req = 8'h08;
		repeat (3) @(negedge mclk);
		chk("int", {7'h00, int_o}, 8'h01);
		ack(8'h43, 1'b1, 3'h0);
		chk("int", {7'h00, int_o}, 8'h00);
		rd(1'b0, 8'h00);
		wr(1'b0, 1'b0, 8'h0b);
		rd(1'b0, 8'h00);
		req = 8'h00;
		ssn = 1'b1;
		wr(1'b0, 1'b0, 8'h18);
		wr(1'b0, 1'b1, 8'h80);
		wr(1'b0, 1'b1, 8'h04);
		chk("cas_en", {7'h00, cas_en}, 8'h01);
		req = 8'h04;
		repeat (3) @(negedge mclk);
		ack(8'h00, 1'b0, 3'h2);
		repeat (3) @(negedge mclk);
		chk("left", 8'(q.size()), 8'h00);
		// Reset again in mid-run while configured as a cascade master
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		chk("idle", {int_o, cas_o, cas_en, den_n, 2'b00}, 8'h04);
		stop_test();
	end
endmodule // testbench
bind pic_host_cascade pic_host_cascade_properties u_prop (.mclk_in, .rst_in, .cs_n_in,
	.rd_n_in, .wr_n_in, .inta_n_in, .request_lines_in, .int_out, .cas_out, .cas_en_out,
	.dout_out, .data_en_n_out);
`default_nettype wire
